// file: core/sac_pkg.sv
// Constants, types and functional notes for the simultaneous ADC conversion control
// Functional notes
// - Reference select high enables internal reference
// - Reference buffer stays enabled except in shutdown
// - After reset, reference mode follows select pin
// - Standby request low powers down; range picks kind
// - Standby keeps reference, regulators; about 100 us wake
// - Shutdown powers everything down; about 13 ms wake
// - Common start rising edge samples all channels
// - Busy rises at start, falls after all channels
// - Busy fall returns all track-and-holds to tracking
// - Results valid for reading when busy falls
// - Start A holds channels 1-4, B holds 5-8
// - Conversion starts at later of both edges
// - All channels converted; same read sequence always
// - Primary and byte selects choose interface mode
// - Oversample code doubles ratio; 111 is invalid
package sac_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS       = 50;
  localparam int STANDBY_WAKE_US     = 100;
  localparam int SHUTDOWN_WAKE_MS    = 13;
  localparam int STANDBY_WAKE_CYCLES = (STANDBY_WAKE_US * 1000) / CLK_PERIOD_NS;
  localparam int SHUTDOWN_WAKE_CYCLES = (SHUTDOWN_WAKE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CONV_SLOT_NS        = 500;
  localparam int CONV_SLOT_CYCLES    = (CONV_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W          = 19;
  localparam int CHANNELS            = 8;
  localparam int ACC_W               = 22;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] CTRL_ADDR       = 4'h0;
  localparam logic [3:0] STATUS_ADDR     = 4'h1;
  localparam logic [3:0] COUNT_ADDR      = 4'h2;
  localparam logic [3:0] RESULT_BASE     = 4'h8;
  localparam int         CTRL_ENABLE_BIT = 0;
  localparam int         CTRL_CLEAR_BIT  = 1;
  localparam logic       CTRL_ENABLE_RST = 1'b1;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] IF_PARALLEL = 2'h0;
  localparam logic [1:0] IF_SERIAL   = 2'h1;
  localparam logic [1:0] IF_BYTE     = 2'h2;
  localparam logic [1:0] IF_INVALID  = 2'h3;
  localparam logic [2:0] OS_INVALID  = 3'h7;

  typedef enum logic [1:0] {
    PWR_ACTIVE   = 2'b00,
    PWR_STANDBY  = 2'b01,
    PWR_WAKE     = 2'b11,
    PWR_SHUTDOWN = 2'b10
  } sac_pwr_type;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_HOLD = 2'b01,
    CV_CONV = 2'b11
  } sac_conv_type;

  typedef struct packed {
    logic       reference_select;
    logic       standby_request_n;
    logic       range_select;
    logic [2:0] oversample_ratio_code;
    logic       interface_select_primary;
    logic       byte_mode_select;
  } sac_pins_type;

  // Idle pin levels after reset: standby request released, internal reference off
  localparam sac_pins_type PINS_RST = 8'h40;

  // Effective oversampling code; the invalid code falls back to no oversampling
  function automatic logic [2:0] sac_os_eff(input logic [2:0] code);
    sac_os_eff = (code == OS_INVALID) ? 3'h0 : code;
  endfunction : sac_os_eff

endpackage : sac_pkg

// file: core/sac_conv_ctrl.sv
// Conversion control, power-down and pin mode logic of the eight channel ADC
`timescale 1ns/1ps
module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter int SHUTDOWN_WAKE = SHUTDOWN_WAKE_CYCLES
)
(
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                sample_start_set_a,
  input  wire logic                sample_start_set_b,
  input  wire sac_pins_type        pins,
  input  wire logic [15:0]         core_data,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic [31:0]              reg_rdata,
  output logic                     busy,
  output logic                     hold_set_a,
  output logic                     hold_set_b,
  output logic                     internal_ref_enable,
  output logic                     ref_buffer_enable,
  output logic                     ref_reg_power,
  output logic                     amp_core_power,
  output logic                     power_ready,
  output logic [2:0]               core_channel,
  output logic                     core_sample,
  output logic [1:0]               interface_mode,
  output logic                     oversample_invalid,
  output logic                     result_valid
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  sac_pins_type pins_meta_reg;
  sac_pins_type pins_reg;
  logic [1:0]   start_meta_reg;
  logic [1:0]   start_sync_reg;
  logic [1:0]   start_prev_reg;
  logic         rise_a;
  logic         rise_b;

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      // Idle levels, so a released reset never looks like a shutdown request
      pins_meta_reg  <= PINS_RST;
      pins_reg       <= PINS_RST;
      start_meta_reg <= 2'h0;
      start_sync_reg <= 2'h0;
      start_prev_reg <= 2'h0;
    end
    else
    begin
      pins_meta_reg  <= pins;
      pins_reg       <= pins_meta_reg;
      start_meta_reg <= {sample_start_set_b, sample_start_set_a};
      start_sync_reg <= start_meta_reg;
      start_prev_reg <= start_sync_reg;
    end

  // Tied starts rise together, giving the all-channel case for free
  assign rise_a = start_sync_reg[0] & ~start_prev_reg[0];
  assign rise_b = start_sync_reg[1] & ~start_prev_reg[1];

  // ****************************************************************
  // Power modes
  // ****************************************************************
  sac_pwr_type           pwr_reg;
  logic [WAKE_CNT_W-1:0] wake_cnt_reg;

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      pwr_reg      <= PWR_WAKE;
      wake_cnt_reg <= WAKE_CNT_W'(STANDBY_WAKE_CYCLES);
    end
    else if (!pins_reg.standby_request_n)
    begin
      pwr_reg      <= pins_reg.range_select ? PWR_STANDBY : PWR_SHUTDOWN;
      wake_cnt_reg <= pins_reg.range_select ? WAKE_CNT_W'(STANDBY_WAKE_CYCLES)
                                            : WAKE_CNT_W'(SHUTDOWN_WAKE);
    end
    else
      case (pwr_reg)
        PWR_ACTIVE:
          pwr_reg <= PWR_ACTIVE;
        PWR_STANDBY, PWR_SHUTDOWN:
          pwr_reg <= PWR_WAKE;
        PWR_WAKE:
        begin
          if (wake_cnt_reg <= WAKE_CNT_W'(1))
            pwr_reg <= PWR_ACTIVE;
          else
            wake_cnt_reg <= wake_cnt_reg - WAKE_CNT_W'(1);
        end
        default:
          pwr_reg <= PWR_WAKE;
      endcase

  // Reference follows the select pin live, so after reset the pin level rules
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      internal_ref_enable <= 1'b0;
      ref_buffer_enable   <= 1'b1;
      ref_reg_power       <= 1'b1;
      amp_core_power      <= 1'b0;
      power_ready         <= 1'b0;
    end
    else
    begin
      internal_ref_enable <= pins_reg.reference_select && pwr_reg != PWR_SHUTDOWN;
      ref_buffer_enable   <= pwr_reg != PWR_SHUTDOWN;
      ref_reg_power       <= pwr_reg != PWR_SHUTDOWN;
      amp_core_power      <= pwr_reg == PWR_ACTIVE || pwr_reg == PWR_WAKE;
      power_ready         <= pwr_reg == PWR_ACTIVE;
    end

  // ****************************************************************
  // Interface mode decode
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      interface_mode     <= IF_PARALLEL;
      oversample_invalid <= 1'b0;
    end
    else
    begin
      case ({pins_reg.interface_select_primary, pins_reg.byte_mode_select})
        2'b00:   interface_mode <= IF_PARALLEL;
        2'b10:   interface_mode <= IF_SERIAL;
        2'b11:   interface_mode <= IF_BYTE;
        default: interface_mode <= IF_INVALID;
      endcase
      oversample_invalid <= pins_reg.oversample_ratio_code == OS_INVALID;
    end

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic        ctrl_enable_reg;
  logic [15:0] conv_count_reg;
  logic        conv_done;

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      ctrl_enable_reg <= CTRL_ENABLE_RST;
    else if (reg_write && reg_addr == CTRL_ADDR)
      ctrl_enable_reg <= reg_wdata[CTRL_ENABLE_BIT];

  // A finishing conversion wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      conv_count_reg <= 16'h0;
    else if (conv_done)
      conv_count_reg <= conv_count_reg + 16'h1;
    else if (reg_write && reg_addr == CTRL_ADDR && reg_wdata[CTRL_CLEAR_BIT])
      conv_count_reg <= 16'h0;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  sac_conv_type cv_reg;
  logic [4:0]   slot_cnt_reg;
  logic [6:0]   round_cnt_reg;
  logic [2:0]   os_reg;
  logic         accept;
  logic         got_a;
  logic         got_b;
  logic         slot_end;
  logic         last_round;

  assign accept     = pwr_reg == PWR_ACTIVE && ctrl_enable_reg;
  assign got_a      = hold_set_a | rise_a;
  assign got_b      = hold_set_b | rise_b;
  assign slot_end   = slot_cnt_reg == 5'(CONV_SLOT_CYCLES - 1);
  assign last_round = round_cnt_reg == 7'((1 << os_reg) - 1);
  assign conv_done  = cv_reg == CV_CONV && slot_end && core_channel == 3'h7 && last_round && accept;

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      cv_reg        <= CV_IDLE;
      busy          <= 1'b0;
      hold_set_a    <= 1'b0;
      hold_set_b    <= 1'b0;
      slot_cnt_reg  <= 5'h0;
      round_cnt_reg <= 7'h0;
      core_channel  <= 3'h0;
      os_reg        <= 3'h0;
    end
    else if (!accept)
    begin
      // Power-down or disable aborts the cycle and releases the holds
      cv_reg     <= CV_IDLE;
      busy       <= 1'b0;
      hold_set_a <= 1'b0;
      hold_set_b <= 1'b0;
    end
    else
      case (cv_reg)
        CV_IDLE, CV_HOLD:
        begin
          hold_set_a <= got_a;
          hold_set_b <= got_b;
          if (got_a && got_b)
          begin
            cv_reg        <= CV_CONV;
            busy          <= 1'b1;
            slot_cnt_reg  <= 5'h0;
            round_cnt_reg <= 7'h0;
            core_channel  <= 3'h0;
            os_reg        <= sac_os_eff(pins_reg.oversample_ratio_code);
          end
          else if (got_a || got_b)
            cv_reg <= CV_HOLD;
        end
        CV_CONV:
        begin
          // Start edges are not looked at here, so a running cycle is safe
          if (!slot_end)
            slot_cnt_reg <= slot_cnt_reg + 5'h1;
          else
          begin
            slot_cnt_reg <= 5'h0;
            core_channel <= core_channel + 3'h1;
            if (core_channel == 3'h7)
            begin
              round_cnt_reg <= round_cnt_reg + 7'h1;
              if (last_round)
              begin
                cv_reg     <= CV_IDLE;
                busy       <= 1'b0;
                hold_set_a <= 1'b0;
                hold_set_b <= 1'b0;
              end
            end
          end
        end
        default:
          cv_reg <= CV_IDLE;
      endcase

  assign core_sample = cv_reg == CV_CONV && slot_cnt_reg == 5'h0;

  // ****************************************************************
  // Accumulation and results
  // ****************************************************************
  logic [ACC_W-1:0] acc_reg [CHANNELS];
  logic [15:0]      result_reg [CHANNELS];
  logic             starting;

  assign starting = accept && cv_reg != CV_CONV && got_a && got_b;

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] avg;

    assign sum = acc_reg[i] + ((core_channel == 3'(i) && slot_end && cv_reg == CV_CONV)
                               ? {{(ACC_W-16){core_data[15]}}, core_data} : ACC_W'(0));
    assign avg = $signed(sum) >>> os_reg;

    always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
        acc_reg[i] <= '0;
      else if (starting)
        acc_reg[i] <= '0;
      else
        acc_reg[i] <= sum;

    // Every channel is stored, used or not, so the read order never changes
    always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
        result_reg[i] <= 16'h0;
      else if (conv_done)
        result_reg[i] <= avg[15:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      result_valid <= 1'b0;
    else if (conv_done)
      result_valid <= 1'b1;
    else if (starting)
      result_valid <= 1'b0;

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      reg_rdata <= 32'h0;
    else if (!reg_read)
      reg_rdata <= 32'h0;
    else if (reg_addr[3])
      reg_rdata <= {16'h0, result_reg[reg_addr[2:0]]};
    else
      case (reg_addr)
        CTRL_ADDR:   reg_rdata <= {31'h0, ctrl_enable_reg};
        STATUS_ADDR: reg_rdata <= {16'h0, 1'b0, oversample_invalid, interface_mode, os_reg,
                                   internal_ref_enable, pwr_reg, power_ready, result_valid,
                                   hold_set_b, hold_set_a, busy, 1'b0};
        COUNT_ADDR:  reg_rdata <= {16'h0, conv_count_reg};
        default:     reg_rdata <= 32'h0;
      endcase

endmodule : sac_conv_ctrl

// file: sim/sac_conv_ctrl_properties.sv
// Port checker for the conversion control block
`timescale 1ns/1ps
module sac_conv_ctrl_properties
  import sac_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         nrst,
  input wire sac_pins_type pins,
  input wire logic         busy,
  input wire logic         hold_set_a,
  input wire logic         hold_set_b,
  input wire logic         internal_ref_enable,
  input wire logic         ref_buffer_enable,
  input wire logic         ref_reg_power,
  input wire logic         amp_core_power,
  input wire logic         power_ready,
  input wire logic [1:0]   interface_mode,
  input wire logic         oversample_invalid,
  input wire logic         result_valid,
  input wire logic [2:0]   core_channel,
  input wire logic         core_sample
);
  logic [15:0] busy_cnt_reg;
  logic [2:0]  os_reg;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      busy_cnt_reg <= 16'h0;
    else
      busy_cnt_reg <= busy ? busy_cnt_reg + 16'h1 : 16'h0;
  // Ratio taken while idle only, as the pin may move during a run
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      os_reg <= 3'h0;
    else if (!busy)
      os_reg <= (pins.oversample_ratio_code == 3'h7) ? 3'h0 : pins.oversample_ratio_code;
  // ************************************************
  // Properties
  // ************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ref_follow_a: assert property ((amp_core_power && $stable(pins))[*5] |->
    internal_ref_enable == pins.reference_select) else $error("reference enable off select");
  buf_on_a: assert property (amp_core_power |-> ref_buffer_enable && ref_reg_power)
    else $error("buffer off while powered");
  standby_request_n_down_a: assert property ((!pins.standby_request_n)[*5] |-> !power_ready && !amp_core_power)
    else $error("no power-down on request");
  standby_request_n_keep_a: assert property ((!pins.standby_request_n && pins.range_select)[*5] |->
    ref_reg_power && ref_buffer_enable) else $error("standby lost reference");
  shut_all_a: assert property ((!pins.standby_request_n && !pins.range_select)[*5] |->
    !ref_buffer_enable && !ref_reg_power && !internal_ref_enable) else $error("shutdown left power on");
  start_hold_a: assert property ($rose(busy) |-> hold_set_a && hold_set_b && power_ready)
    else $error("busy rose without both holds");
  conv_len_a: assert property ($rose(result_valid) |-> $fell(busy) && busy_cnt_reg == (16'h50 << os_reg))
    else $error("conversion length wrong");
  track_fall_a: assert property ($fell(busy) |-> !hold_set_a && !hold_set_b)
    else $error("holds kept after busy fall");
  valid_clr_a: assert property ($rose(busy) |=> !result_valid)
    else $error("stale results during run");
  conv_steady_a: assert property (busy && $past(busy) |-> hold_set_a && hold_set_b && !result_valid)
    else $error("run disturbed while busy");
  mode_pins_a: assert property ($stable(pins)[*5] |-> interface_mode ==
    (pins.interface_select_primary ? (pins.byte_mode_select ? 2'h2 : 2'h1) : (pins.byte_mode_select ? 2'h3 : 2'h0)))
    else $error("interface mode wrong");
  os_flag_a: assert property ($stable(pins)[*5] |-> oversample_invalid == (pins.oversample_ratio_code == 3'h7))
    else $error("oversample flag wrong");
  chan_step_a: assert property (core_sample && core_channel != 3'h7 |->
    ##10 core_sample && core_channel == $past(core_channel, 10) + 3'h1) else $error("channel slot out of step");
  cover property ($rose(result_valid) && os_reg != 3'h0);
  cover property ($rose(busy) && $past(hold_set_b, 2) && !$past(hold_set_a, 2));
  cover property ($fell(ref_reg_power));
endmodule : sac_conv_ctrl_properties

// file: sim/sac_host_model.sv
// Host model issuing sample-start edges to both channel sets
`timescale 1ns/1ps
module sac_host_model
(
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic [7:0] skew,
  input  wire logic       b_first,
  output logic            sample_start_set_a,
  output logic            sample_start_set_b
);
  logic [7:0] cnt_reg;
  initial
  begin
    sample_start_set_a = 1'b0;
    sample_start_set_b = 1'b0;
    cnt_reg = 8'h0;
  end
  // Lines stay high 8 cycles past the later edge; the device needs 3 to see it
  always @(posedge ref_clk)
  begin
    if (fire)
    begin
      sample_start_set_a <= !b_first || skew == 8'h0;
      sample_start_set_b <= b_first || skew == 8'h0;
      cnt_reg <= 8'h1;
    end
    else if (cnt_reg != 8'h0)
    begin
      cnt_reg <= cnt_reg + 8'h1;
      if (cnt_reg == skew)
      begin
        sample_start_set_a <= 1'b1;
        sample_start_set_b <= 1'b1;
      end
      if (cnt_reg == skew + 8'h8)
      begin
        sample_start_set_a <= 1'b0;
        sample_start_set_b <= 1'b0;
        cnt_reg <= 8'h0;
      end
    end
  end
endmodule : sac_host_model

// file: sim/testbench.sv
// Self-checking testbench for the conversion control block
`timescale 1ns/1ps
module testbench;
  import sac_pkg::*;
  logic         ref_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         sample_start_set_a, sample_start_set_b;
  sac_pins_type pins = 8'he0;
  logic [15:0]  core_data = 16'h1a2b;
  logic [3:0]   reg_addr = 4'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_write = 1'b0;
  logic         reg_read = 1'b0;
  logic [31:0]  reg_rdata, rd_q;
  logic         busy, hold_set_a, hold_set_b, internal_ref_enable, ref_buffer_enable;
  logic         ref_reg_power, amp_core_power, power_ready, oversample_invalid, result_valid;
  logic [1:0]   interface_mode;
  logic         fire = 1'b0;
  logic         b_first = 1'b0;
  logic [7:0]   skew = 8'h0;
  int           len;
  int           error_cnt = 0;
  int           checks_done = 0;
  // Short shutdown wake keeps the run brief
  sac_conv_ctrl #(.SHUTDOWN_WAKE(50)) u_dut (.ref_clk, .nrst, .sample_start_set_a, .sample_start_set_b,
    .pins, .core_data, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .busy, .hold_set_a,
    .hold_set_b, .internal_ref_enable, .ref_buffer_enable, .ref_reg_power, .amp_core_power, .power_ready,
    .core_channel(), .core_sample(), .interface_mode, .oversample_invalid, .result_valid);
  sac_host_model u_host (.ref_clk, .fire, .skew, .b_first, .sample_start_set_a, .sample_start_set_b);
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    rd_q = reg_rdata;
  endtask : rd
  task automatic start(input logic [7:0] s, input logic bf);
    @(posedge ref_clk);
    fire    <= 1'b1;
    skew    <= s;
    b_first <= bf;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask : start
  task automatic finish_conv(output int n);
    int w;
    w = 0;
    while (busy !== 1'b1 && w < 400)
    begin
      @(negedge ref_clk);
      w++;
    end
    n = 0;
    while (busy === 1'b1 && n < 9000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (w >= 400 || n >= 9000)
      error_cnt++;
  endtask : finish_conv
  task automatic wait_ready();
    int n;
    n = 0;
    while (power_ready !== 1'b1 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 3000)
      error_cnt++;
  endtask : wait_ready
  task automatic set_os(input logic [2:0] c);
    @(posedge ref_clk);
    pins.oversample_ratio_code <= c;
    repeat (5) @(negedge ref_clk);
  endtask : set_os
  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_common();
    start(8'h0, 1'b0);
    finish_conv(len);
    check(len, 32'h50);
    rd(STATUS_ADDR);
    check(rd_q[8:1], 32'h98);
    for (int a = 8; a < 16; a++)
    begin
      rd(a[3:0]);
      check(rd_q, 32'h1a2b);
    end
    wr(4'h5, 32'hffff);
    rd(4'h5);
    check(rd_q, 32'h0);
    rd(COUNT_ADDR);
    check(rd_q, 32'h1);
    $display("common start done");
  endtask : t_common
  task automatic t_two_set();
    start(8'h14, 1'b1);
    repeat (8) @(negedge ref_clk);
    check({hold_set_a, hold_set_b, busy}, 32'h2);
    finish_conv(len);
    check(len, 32'h50);
    $display("two-set start done");
  endtask : t_two_set
  task automatic t_ignore();
    wr(CTRL_ADDR, 32'h3);
    start(8'h0, 1'b0);
    repeat (30) @(negedge ref_clk);
    start(8'h0, 1'b0);
    finish_conv(len);
    check(len, 32'h35);
    repeat (20) @(negedge ref_clk);
    check(busy, 32'h0);
    rd(COUNT_ADDR);
    check(rd_q, 32'h1);
    $display("busy start ignore done");
  endtask : t_ignore
  task automatic t_os();
    for (int c = 0; c < 8; c++)
    begin
      set_os(c[2:0]);
      check(oversample_invalid, {31'h0, c == 7});
    end
    set_os(3'h1);
    start(8'h0, 1'b0);
    finish_conv(len);
    check(len, 32'ha0);
    set_os(3'h7);
    start(8'h0, 1'b0);
    finish_conv(len);
    check(len, 32'h50);
    set_os(3'h0);
    $display("oversampling done");
  endtask : t_os
  task automatic t_iface();
    logic [1:0] exp_if [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      {pins.interface_select_primary, pins.byte_mode_select} <= i[1:0];
      repeat (5) @(negedge ref_clk);
      check(interface_mode, exp_if[i]);
    end
    $display("interface select done");
  endtask : t_iface
  task automatic t_power();
    @(posedge ref_clk);
    pins.standby_request_n <= 1'b0;
    repeat (8) @(negedge ref_clk);
    check({power_ready, amp_core_power, ref_reg_power, ref_buffer_enable}, 32'h3);
    @(posedge ref_clk);
    pins.standby_request_n <= 1'b1;
    repeat (1990) @(negedge ref_clk);
    check(power_ready, 32'h0);
    repeat (20) @(negedge ref_clk);
    check(power_ready, 32'h1);
    @(posedge ref_clk);
    pins <= 8'h00;
    repeat (8) @(negedge ref_clk);
    check({ref_buffer_enable, ref_reg_power, internal_ref_enable, amp_core_power}, 32'h0);
    @(posedge ref_clk);
    pins <= 8'h60;
    repeat (60) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_ready();
    check(internal_ref_enable, 32'h0);
    @(posedge ref_clk);
    pins.reference_select <= 1'b1;
    repeat (5) @(negedge ref_clk);
    check(internal_ref_enable, 32'h1);
    $display("power modes done");
  endtask : t_power
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    check({ref_buffer_enable, busy}, 32'h2);
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_ready();
    check(internal_ref_enable, 32'h1);
    t_common();
    t_two_set();
    t_ignore();
    t_os();
    t_iface();
    t_power();
    wrap_up();
  end
endmodule : testbench
bind sac_conv_ctrl sac_conv_ctrl_properties u_chk (.ref_clk, .nrst, .pins, .busy, .hold_set_a, .hold_set_b,
  .internal_ref_enable, .ref_buffer_enable, .ref_reg_power, .amp_core_power, .power_ready, .interface_mode,
  .oversample_invalid, .result_valid, .core_channel, .core_sample);
